// [sps_supervisor.sv]
// Servo protection and stop sequencing with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sps_defines.svh"

module sps_supervisor
  import sps_pkg::*;
#(
  parameter int CYC_PER_MS = `SPS_MS_NS / `SPS_CLK_NS,
  parameter int ACC_TICK   = `SPS_MS_NS / `SPS_CLK_NS
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  input  wire logic [17:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [17:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  input  wire logic [15:0] I_TORQUE_FB,
  input  wire logic        I_MOTOR_STOPPED,
  input  wire logic [15:0] I_CUR_A,
  input  wire logic [15:0] I_CUR_B,
  input  wire logic [15:0] I_CUR_C,
  input  wire logic        I_FWD_LIMIT,
  input  wire logic        I_REV_LIMIT,
  input  wire logic        I_EMERGENCY_HALT,
  input  wire logic        I_INDEX_LOSS,
  input  wire logic [7:0]  I_WARN_RAW,
  output logic             O_PWM_EN,
  output logic             O_BRAKE_ENGAGE,
  output logic             O_DYNAMIC_BRAKE,
  output logic             O_TORQUE_ZERO,
  output logic             O_EMERGENCY_HALT_INPUT_DECEL,
  output logic [7:0]       O_WARNINGS,
  output logic             O_OVL_ALARM,
  output logic             O_INDEX_ALARM,
  output logic             O_REGEN_PEAK_EN,
  output logic [15:0]      O_CUR_A,
  output logic [15:0]      O_CUR_B,
  output logic [15:0]      O_CUR_C,
  output logic             O_IRQ
);

  localparam logic [19:0] MS_LAST  = 20'(CYC_PER_MS - 1);
  localparam logic [19:0] ACC_LAST = 20'(ACC_TICK - 1);
  localparam sps_resp_t   R_OKAY   = 2'h0;
  localparam sps_resp_t   R_SLVERR = 2'h2;

  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic        arrdy;
    logic        aw_ok;
    logic        w_ok;
    logic [15:0] aw_idx;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        bvalid;
    sps_resp_t   bresp;
    logic        rvalid;
    logic [31:0] rdata;
    sps_resp_t   rresp;
    logic [15:0] base;
    logic [15:0] level;
    logic [15:0] delay;
    logic [15:0] brk_mode;
    logic [15:0] meth;
    logic [15:0] mask;
    logic [15:0] ofs_a;
    logic [15:0] ofs_b;
    logic [15:0] ofs_c;
    logic [2:0]  ctrl;
    logic [4:0]  status;
    logic [4:0]  enable;
    logic [2:0]  lim_f;
    logic [2:0]  lim_r;
    logic [2:0]  halt;
    logic [1:0]  idx;
    logic [7:0]  warn_s1;
    logic [7:0]  warn_s2;
    logic [19:0] acc_cnt;
    logic [15:0] acc;
    logic        ovl_warn;
    logic        ovl_alarm;
    sps_phase_t  st;
    logic [19:0] ms_cnt;
    logic [15:0] delay_ms;
    logic        pwm_en;
    logic        brake;
    logic        db;
    logic        tq_zero;
    logic        decel;
    logic [7:0]  warnings;
    logic        idx_alarm;
    logic        regen_peak;
    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [15:0] cur_c;
    logic        irq;
  } sps_regs_t;

  sps_regs_t   q;
  sps_regs_t   d;
  logic        wr_go;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] rd_val;
  logic [15:0] tq_abs;
  logic        above;
  logic [19:0] lvl_pct;
  logic        trig;
  logic        eff_decel;
  logic        stop_req;
  logic [4:0]  ev;
  logic [7:0]  warn_vec;
  logic [15:0] corr_a;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  assign corr_a = I_CUR_A - q.ofs_a;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    wr_go = 1'b0;
    wr_hit = 1'b1;
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    ev = 5'h00;
    // The second stage of each synchroniser feeds logic; the third stage of the limit and halt ones feeds only the edge detect
    d.lim_f = {q.lim_f[1:0], I_FWD_LIMIT};
    d.lim_r = {q.lim_r[1:0], I_REV_LIMIT};
    d.halt = {q.halt[1:0], I_EMERGENCY_HALT};
    d.idx = {q.idx[0], I_INDEX_LOSS};
    d.warn_s1 = I_WARN_RAW;
    d.warn_s2 = q.warn_s1;

    // Write channel: address and data taken in either order
    if (q.awrdy && I_AWVALID) begin
      d.aw_ok = 1'b1;
      d.aw_idx = I_AWADDR[17:2];
    end
    if (q.wrdy && I_WVALID) begin
      d.w_ok = 1'b1;
      d.wdata = I_WDATA[15:0];
      d.wstrb = I_WSTRB[1:0];
    end
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      wr_go = 1'b1;
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
    end else if (q.bvalid && I_BREADY) begin
      d.bvalid = 1'b0;
    end
    d.awrdy = !d.aw_ok && !d.bvalid;
    d.wrdy = !d.w_ok && !d.bvalid;

    if (wr_go) begin
      unique case (q.aw_idx)
        `SPS_IDX_OVL_BASE:   d.base = merge16(q.base, q.wdata, q.wstrb);
        `SPS_IDX_WARN_LVL:   d.level = merge16(q.level, q.wdata, q.wstrb);
        `SPS_IDX_OFF_DELAY:  d.delay = merge16(q.delay, q.wdata, q.wstrb);
        `SPS_IDX_BRK_MODE:   d.brk_mode = merge16(q.brk_mode, q.wdata,
                                                  q.wstrb);
        `SPS_IDX_EMERGENCY_HALT_INPUT_METH: d.meth = merge16(q.meth, q.wdata, q.wstrb);
        `SPS_IDX_WARN_MASK:  d.mask = merge16(q.mask, q.wdata, q.wstrb);
        `SPS_IDX_OFS_A:      d.ofs_a = merge16(q.ofs_a, q.wdata,
                                               q.wstrb);
        `SPS_IDX_OFS_B:      d.ofs_b = merge16(q.ofs_b, q.wdata, q.wstrb);
        `SPS_IDX_OFS_C:      d.ofs_c = merge16(q.ofs_c, q.wdata, q.wstrb);
        `SPS_IDX_CTRL: begin
          if (q.wstrb[0]) begin
            d.ctrl = q.wdata[2:0];
          end
        end
        `SPS_IDX_CLEAR, `SPS_IDX_STATUS, `SPS_IDX_ACC, `SPS_IDX_WARN_OUT: ;
        `SPS_IDX_ENABLE: begin
          if (q.wstrb[0]) begin
            d.enable = q.wdata[4:0];
          end
        end
        default: wr_hit = 1'b0;
      endcase
      d.bresp = wr_hit ? R_OKAY : R_SLVERR;
    end

    // Read channel: one read in flight, data one cycle after address
    unique case (I_ARADDR[17:2])
      `SPS_IDX_OVL_BASE:   rd_val = q.base;
      `SPS_IDX_WARN_LVL:   rd_val = q.level;
      `SPS_IDX_OFF_DELAY:  rd_val = q.delay;
      `SPS_IDX_BRK_MODE:   rd_val = q.brk_mode;
      `SPS_IDX_EMERGENCY_HALT_INPUT_METH: rd_val = q.meth;
      `SPS_IDX_WARN_MASK:  rd_val = q.mask;
      `SPS_IDX_OFS_A:      rd_val = q.ofs_a;
      `SPS_IDX_OFS_B:      rd_val = q.ofs_b;
      `SPS_IDX_OFS_C:      rd_val = q.ofs_c;
      `SPS_IDX_CTRL:       rd_val = {13'h0000, q.ctrl};
      `SPS_IDX_STATUS:     rd_val = {11'h000, q.status};
      `SPS_IDX_CLEAR:      rd_val = 16'h0000;
      `SPS_IDX_ENABLE:     rd_val = {11'h000, q.enable};
      `SPS_IDX_ACC:        rd_val = q.acc;
      `SPS_IDX_WARN_OUT:   rd_val = {q.ovl_alarm, q.idx_alarm, 6'h00,
                                     q.warnings};
      default:             rd_hit = 1'b0;
    endcase
    if (q.arrdy && I_ARVALID) begin
      d.arrdy = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = {16'h0000, rd_val};
      d.rresp = rd_hit ? R_OKAY : R_SLVERR;
    end else if (q.rvalid && I_RREADY) begin
      d.rvalid = 1'b0;
      d.arrdy = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overload figure in 0.1% steps; base and level are whole percent
    tq_abs = I_TORQUE_FB[15] ? 16'(-I_TORQUE_FB) : I_TORQUE_FB;
    above = {4'h0, tq_abs} > 20'({4'h0, q.base} * `SPS_PCT_SCALE);
    lvl_pct = 20'({4'h0, q.level} * `SPS_PCT_SCALE);
    d.acc_cnt = (q.acc_cnt == ACC_LAST) ? 20'h00000 : q.acc_cnt + 20'h00001;
    if (q.acc_cnt == ACC_LAST) begin
      // Cooling down below the base keeps the warning honest over time
      if (above && {4'h0, q.acc} < `SPS_ACC_FULL) begin
        d.acc = q.acc + 16'h0001;
      end else if (!above && q.acc != 16'h0000) begin
        d.acc = q.acc - 16'h0001;
      end
    end
    if ({4'h0, q.acc} >= `SPS_ACC_FULL) begin
      d.ovl_alarm = 1'b1;
    end else if (wr_go && q.aw_idx == `SPS_IDX_CTRL && q.wstrb[0] &&
                 q.wdata[`SPS_CTRL_ALM_RST]) begin
      d.ovl_alarm = 1'b0;
    end
    // Warning yields to the alarm, and follows the level otherwise
    d.ovl_warn = !d.ovl_alarm &&
                 ({4'h0, q.acc} >= lvl_pct);

    ////////////////////////////////////////////////////////////////////////////
    // Emergency handling
    trig = q.lim_f[1] || q.lim_r[1] || q.halt[1];
    eff_decel = q.meth[0] && !q.ctrl[`SPS_CTRL_TQ_MODE];
    stop_req = !q.ctrl[`SPS_CTRL_SERVO_ON] || q.ovl_alarm ||
               (trig && !eff_decel);

    unique case (q.st)
      SPS_RUN: begin
        if (stop_req) begin
          d.st = SPS_DELAY;
          d.ms_cnt = 20'h00000;
          d.delay_ms = q.delay;
        end
      end
      SPS_DELAY: begin
        // Drive stays on while the holding brake takes the load
        if (q.delay_ms == 16'h0000) begin
          d.st = SPS_STOP;
          ev[`SPS_EV_STOPPED] = 1'b1;
        end else if (q.ms_cnt == MS_LAST) begin
          d.ms_cnt = 20'h00000;
          d.delay_ms = q.delay_ms - 16'h0001;
        end else begin
          d.ms_cnt = q.ms_cnt + 20'h00001;
        end
      end
      SPS_STOP: begin
        if (!stop_req) begin
          d.st = SPS_RUN;
        end
      end
    endcase

    d.pwm_en = d.st != SPS_STOP;
    d.brake = d.st != SPS_RUN;
    d.db = 1'b0;
    if (d.st == SPS_STOP) begin
      unique case (q.brk_mode[1:0])
        2'h0: d.db = 1'b1;
        2'h1: d.db = !I_MOTOR_STOPPED;
        2'h2: d.db = 1'b0;
        2'h3: d.db = I_MOTOR_STOPPED;
      endcase
    end
    d.tq_zero = trig && !eff_decel;
    d.decel = trig && eff_decel && q.st == SPS_RUN;

    // Warning bits 4 and 7 are produced here, the rest come from pins
    warn_vec = q.warn_s2;
    warn_vec[`SPS_MSK_OVL_WARN] = q.ovl_warn;
    warn_vec[`SPS_MSK_EMERGENCY_HALT_INPUT_WARN] = q.halt[1];
    d.warnings = warn_vec & ~q.mask[7:0];
    d.idx_alarm = q.idx[1] && !q.mask[`SPS_MSK_INDEX];
    d.regen_peak = q.ctrl[`SPS_CTRL_REGEN_EXT];
    d.cur_a = corr_a;
    d.cur_b = I_CUR_B - q.ofs_b;
    d.cur_c = I_CUR_C - q.ofs_c;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status; a new event wins over a clear in the same cycle
    ev[`SPS_EV_WARN] = d.ovl_warn && !q.ovl_warn;
    ev[`SPS_EV_ALARM] = d.ovl_alarm && !q.ovl_alarm;
    ev[`SPS_EV_INDEX] = d.idx_alarm && !q.idx_alarm;
    // Any rise of the synchronised trigger counts, whatever the stop method
    ev[`SPS_EV_EMERGENCY_HALT_INPUT] = trig && !(q.lim_f[2] || q.lim_r[2] || q.halt[2]);
    d.status = q.status;
    if (wr_go && q.aw_idx == `SPS_IDX_CLEAR && q.wstrb[0]) begin
      d.status = q.status & ~q.wdata[4:0];
    end
    d.status = d.status | ev;
    d.irq = |(d.status & d.enable);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      q <= '0;
      q.awrdy <= 1'b1;
      q.wrdy <= 1'b1;
      q.arrdy <= 1'b1;
      q.base <= `SPS_RST_OVL_BASE;
      q.level <= `SPS_RST_WARN_LVL;
      q.delay <= `SPS_RST_OFF_DELAY;
      q.brk_mode <= `SPS_RST_BRK_MODE;
      q.meth <= `SPS_RST_EMERGENCY_HALT_INPUT_METH;
      q.mask <= `SPS_RST_WARN_MASK;
      q.ofs_a <= `SPS_RST_OFS;
      q.ofs_b <= `SPS_RST_OFS;
      q.ofs_c <= `SPS_RST_OFS;
      q.ctrl <= `SPS_RST_CTRL;
      q.st <= SPS_STOP;
      q.brake <= 1'b1;
      q.db <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign O_AWREADY       = q.awrdy;
  assign O_WREADY        = q.wrdy;
  assign O_BRESP         = q.bresp;
  assign O_BVALID        = q.bvalid;
  assign O_ARREADY       = q.arrdy;
  assign O_RDATA         = q.rdata;
  assign O_RRESP         = q.rresp;
  assign O_RVALID        = q.rvalid;
  assign O_PWM_EN        = q.pwm_en;
  assign O_BRAKE_ENGAGE  = q.brake;
  assign O_DYNAMIC_BRAKE = q.db;
  assign O_TORQUE_ZERO   = q.tq_zero;
  assign O_EMERGENCY_HALT_INPUT_DECEL   = q.decel;
  assign O_WARNINGS      = q.warnings;
  assign O_OVL_ALARM     = q.ovl_alarm;
  assign O_INDEX_ALARM   = q.idx_alarm;
  assign O_REGEN_PEAK_EN = q.regen_peak;
  assign O_CUR_A         = q.cur_a;
  assign O_CUR_B         = q.cur_b;
  assign O_CUR_C         = q.cur_c;
  assign O_IRQ           = q.irq;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  chk_acc_rises_above: assert property (
    q.acc > $past(q.acc) |-> $past(above))
    else $error("overload figure grew without torque above base");
  chk_alarm_at_full: assert property (
    {4'h0, q.acc} >= `SPS_ACC_FULL |=> q.ovl_alarm && !q.ovl_warn)
    else $error("full overload figure did not raise the alarm");
  chk_warn_at_level: assert property (
    !q.ovl_alarm && {4'h0, q.acc} >= lvl_pct && {4'h0, q.acc} < `SPS_ACC_FULL
    |=> q.ovl_warn)
    else $error("warning missing at programmed level");
  chk_warn_drops: assert property (
    !q.ovl_alarm && {4'h0, q.acc} < lvl_pct |=> !q.ovl_warn)
    else $error("warning held below level");
  chk_drive_in_delay: assert property (
    q.st == SPS_DELAY |-> q.pwm_en && q.brake)
    else $error("power stage off during off delay");
  chk_brake_first: assert property (
    $fell(q.pwm_en) |-> $past(q.brake) && q.brake)
    else $error("drive switched off before brake engaged");
  chk_coast_no_db: assert property (
    q.st == SPS_STOP && $past(q.brk_mode[1:0]) == 2'h2 |-> !q.db)
    else $error("dynamic brake in coast and release mode");
  chk_method_excl: assert property (
    q.tq_zero |-> !q.decel)
    else $error("zero torque and deceleration together");
  chk_torque_mode: assert property (
    q.ctrl[`SPS_CTRL_TQ_MODE] |=> !q.decel)
    else $error("stop torque deceleration in torque mode");
  chk_warn_masked: assert property (
    q.mask[7:0] == $past(q.mask[7:0]) |-> (q.warnings & q.mask[7:0]) == 8'h00)
    else $error("masked warning shown");
  chk_index_masked: assert property (
    q.mask[`SPS_MSK_INDEX] && $past(q.mask[`SPS_MSK_INDEX]) |-> !q.idx_alarm)
    else $error("masked index alarm shown");
  chk_regen_internal: assert property (
    !$past(q.ctrl[`SPS_CTRL_REGEN_EXT]) |-> !q.regen_peak)
    else $error("peak limit applied with internal resistor");
  chk_offset_sub: assert property (
    q.cur_a == 16'($past(I_CUR_A) - $past(q.ofs_a)))
    else $error("phase A offset not subtracted");

  cov_alarm: cover property (q.ovl_warn ##[1:1000] q.ovl_alarm);
  cov_off_seq: cover property (q.st == SPS_RUN ##1 q.st == SPS_DELAY
                               ##[1:300] q.st == SPS_STOP);
  cov_decel: cover property (q.decel);
  cov_irq: cover property ($rose(q.irq));

endmodule

// [sps_defines.svh]
// Offsets, field positions, reset values and timing counts of the supervisor
// Function
// - Overload figure grows only while torque exceeds the base, 10..120%.
// - Overload figure at 100% turns the warning into the continuous alarm.
// - Overload warning raised once figure reaches the warning level.
// - After servo-off the power stage keeps switching for the off delay.
// - Holding brake engages before the delayed power stage switch-off.
// - Dynamic brake mode 0..3 selects brake or coast, then hold or release.
// - Emergency method 0 stops per brake mode, torque command held at zero.
// - Emergency method 1 decelerates to stop using emergency stop torque.
// - Torque control mode never uses the emergency stop torque deceleration.
// - Warnings whose bit is set in the 16-bit mask are suppressed.
// - Mask bits 0..7 map to the eight individual warnings.
// - Mask bit 14 suppresses the index pulse loss alarm.
// - Each phase holds a signed current offset, -1000..1000, reset zero.
// - Peak regeneration limit applies only with the external resistor.
// - Each phase offset is subtracted from its measured current.
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

`define SPS_IDX_OVL_BASE   16'h200f
`define SPS_IDX_WARN_LVL   16'h2010
`define SPS_IDX_OFF_DELAY  16'h2011
`define SPS_IDX_BRK_MODE   16'h2012
`define SPS_IDX_EMERGENCY_HALT_INPUT_METH 16'h2013
`define SPS_IDX_WARN_MASK  16'h2014
`define SPS_IDX_OFS_A      16'h2015
`define SPS_IDX_OFS_B      16'h2016
`define SPS_IDX_OFS_C      16'h2017
`define SPS_IDX_CTRL       16'h2100
`define SPS_IDX_STATUS     16'h2101
`define SPS_IDX_CLEAR      16'h2102
`define SPS_IDX_ENABLE     16'h2103
`define SPS_IDX_ACC        16'h2104
`define SPS_IDX_WARN_OUT   16'h2105

`define SPS_RST_OVL_BASE   16'h0064
`define SPS_RST_WARN_LVL   16'h0032
`define SPS_RST_OFF_DELAY  16'h000a
`define SPS_RST_BRK_MODE   16'h0000
`define SPS_RST_EMERGENCY_HALT_INPUT_METH 16'h0001
`define SPS_RST_WARN_MASK  16'h0000
`define SPS_RST_OFS        16'h0000
`define SPS_RST_CTRL       3'h4

`define SPS_CTRL_SERVO_ON  0
`define SPS_CTRL_TQ_MODE   1
`define SPS_CTRL_REGEN_EXT 2
`define SPS_CTRL_ALM_RST   3

`define SPS_EV_WARN        0
`define SPS_EV_ALARM       1
`define SPS_EV_INDEX       2
`define SPS_EV_EMERGENCY_HALT_INPUT       3
`define SPS_EV_STOPPED     4

`define SPS_MSK_OVL_WARN   4
`define SPS_MSK_EMERGENCY_HALT_INPUT_WARN 7
`define SPS_MSK_INDEX      14

`define SPS_ACC_FULL       20'h003e8
`define SPS_PCT_SCALE      20'h0000a
`define SPS_MS_NS          1000000
`define SPS_CLK_NS         50

`endif

// [sps_pkg.sv]
// Types shared by the servo protection and stop supervisor
package sps_pkg;

  typedef enum logic [1:0] {
    SPS_RUN,
    SPS_DELAY,
    SPS_STOP
  } sps_phase_t;

  typedef logic [1:0] sps_resp_t;

endpackage

// [sps_motor_model.sv]
// Behavioural motor, power stage and dynamic brake on the far side
`timescale 1ns/1ps
module sps_motor_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_pwm_en,
  input  wire logic        i_dyn_brake,
  input  wire logic        i_torque_zero,
  input  wire logic [15:0] i_load,
  output logic             o_stopped,
  output logic [15:0]      o_torque_fb
);
  logic [4:0] speed_q;
  // Dynamic brake stops the shaft twice as fast as a free run
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      speed_q <= 5'h00;
    end else if (i_pwm_en && !i_torque_zero) begin
      speed_q <= (speed_q == 5'h10) ? speed_q : speed_q + 5'h01;
    end else if (speed_q > 5'h01 && i_dyn_brake) begin
      speed_q <= speed_q - 5'h02;
    end else if (speed_q != 5'h00) begin
      speed_q <= speed_q - 5'h01;
    end
  end
  assign o_stopped   = (speed_q == 5'h00);
  // No torque is produced while the stage is off or held at zero
  assign o_torque_fb = (i_pwm_en && !i_torque_zero) ? i_load : 16'h0000;
endmodule

// [tb.sv]
// Self-checking testbench of the protection and stop supervisor
`timescale 1ns/1ps
`include "sps_defines.svh"
module tb;
  logic        clk, rst, awv, wv, brdy, arv, rrdy, fwd, rev, halt, idx;
  logic [17:0] awa, ara;
  logic [31:0] wd, last_data;
  logic [3:0]  ws;
  logic [7:0]  wraw;
  logic [15:0] load, cur_a, cur_b, cur_c;
  logic [1:0]  last_resp;
  wire         awr, wr, bv, arr, rv, stopped, pwm, brk, db, tz, ed;
  wire         ovl, ial, rgn, irq;
  wire  [1:0]  br, rr;
  wire  [31:0] rd;
  wire  [7:0]  warn;
  wire  [15:0] tfb, oa, ob, oc;
  int          mismatches, check_count;

  sps_supervisor #(.CYC_PER_MS(4), .ACC_TICK(2)) uut (
    .I_SYS_CLK(clk), .I_RST(rst), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv),
    .O_WREADY(wr), .O_BRESP(br), .O_BVALID(bv), .I_BREADY(brdy),
    .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rd),
    .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rrdy), .I_TORQUE_FB(tfb),
    .I_MOTOR_STOPPED(stopped), .I_CUR_A(cur_a), .I_CUR_B(cur_b),
    .I_CUR_C(cur_c), .I_FWD_LIMIT(fwd), .I_REV_LIMIT(rev),
    .I_EMERGENCY_HALT(halt), .I_INDEX_LOSS(idx), .I_WARN_RAW(wraw),
    .O_PWM_EN(pwm), .O_BRAKE_ENGAGE(brk), .O_DYNAMIC_BRAKE(db),
    .O_TORQUE_ZERO(tz), .O_EMERGENCY_HALT_INPUT_DECEL(ed), .O_WARNINGS(warn),
    .O_OVL_ALARM(ovl), .O_INDEX_ALARM(ial), .O_REGEN_PEAK_EN(rgn),
    .O_CUR_A(oa), .O_CUR_B(ob), .O_CUR_C(oc), .O_IRQ(irq));

  sps_motor_model motor (.i_clk(clk), .i_rst(rst), .i_pwm_en(pwm),
    .i_dyn_brake(db), .i_torque_zero(tz), .i_load(load),
    .o_stopped(stopped), .o_torque_fb(tfb));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // Address and data offered together; each dropped once its ready is seen
  task automatic wr_reg(input logic [15:0] ix, input logic [15:0] d);
    @(posedge clk);
    awa <= {ix, 2'b00};
    wd <= {16'h0000, d};
    ws <= 4'h3;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) begin
        last_resp = br;
        brdy <= 1'b0;
        return;
      end
    end
    mismatches++;
  endtask

  task automatic rd_reg(input logic [15:0] ix);
    @(posedge clk);
    ara <= {ix, 2'b00};
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        last_resp = rr;
        last_data = rd;
        rrdy <= 1'b0;
        return;
      end
    end
    mismatches++;
  endtask

  task automatic servo_on(input logic [15:0] c);
    wr_reg(`SPS_IDX_CTRL, c);
    for (int n = 0; n < 100 && !pwm; n++) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    logic [15:0] ev [9];
    ev = '{16'h0064, 16'h0032, 16'h000a, 16'h0000, 16'h0001, 16'h0000,
           16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 9; i++) begin
      rd_reg(`SPS_IDX_OVL_BASE + 16'(i));
      chk("reset value", {16'h0000, ev[i]}, last_data);
    end
    rd_reg(16'h2000);
    chk("unmapped read resp", 32'h2, {30'h0, last_resp});
    wr_reg(16'h2000, 16'h1234);
    chk("unmapped write resp", 32'h2, {30'h0, last_resp});
  endtask

  task automatic t_offsets();
    wr_reg(`SPS_IDX_OFS_A, 16'hfc18);
    wr_reg(`SPS_IDX_OFS_B, 16'h03e8);
    wr_reg(`SPS_IDX_OFS_C, 16'h0005);
    cur_a <= 16'h0000;
    cur_b <= 16'h0100;
    cur_c <= 16'h0010;
    repeat (4) @(posedge clk);
    chk("current a", 32'h03e8, {16'h0, oa});
    chk("current b", 32'hfd18, {16'h0, ob});
    chk("current c", 32'h000b, {16'h0, oc});
    rd_reg(`SPS_IDX_OFS_A);
    chk("offset a", 32'hfc18, last_data);
  endtask

  task automatic t_mask();
    for (int i = 0; i < 7; i++) begin
      if (i == 4) continue;
      wraw <= 8'h01 << i;
      repeat (6) @(posedge clk);
      chk("warning out", 32'h1 << i, {24'h0, warn});
      wr_reg(`SPS_IDX_WARN_MASK, 16'h0001 << i);
      repeat (3) @(posedge clk);
      chk("masked warning", 32'h0, {24'h0, warn});
    end
    wraw <= 8'h00;
    wr_reg(`SPS_IDX_WARN_MASK, 16'h4000);
    idx <= 1'b1;
    repeat (6) @(posedge clk);
    chk("masked index alarm", 32'h0, {31'h0, ial});
    idx <= 1'b0;
    wr_reg(`SPS_IDX_WARN_MASK, 16'h0000);
    idx <= 1'b1;
    repeat (6) @(posedge clk);
    chk("index alarm", 32'h1, {31'h0, ial});
    idx <= 1'b0;
  endtask

  task automatic t_off_delay(input int d);
    int n;
    wr_reg(`SPS_IDX_OFF_DELAY, 16'(d));
    servo_on(16'h0005);
    wr_reg(`SPS_IDX_CTRL, 16'h0004);
    for (n = 0; n < 20 && !brk; n++) @(posedge clk);
    chk("brake engaged", 32'h1, {31'h0, brk});
    chk("pwm while brake", 32'h1, {31'h0, pwm});
    for (n = 0; n < 100 && pwm; n++) @(posedge clk);
    chk("off delay cycles", d * 4 + 1, n);
  endtask

  task automatic t_modes();
    logic [3:0] ex;
    ex = 4'b1001;
    for (int m = 0; m < 4; m++) begin
      wr_reg(`SPS_IDX_BRK_MODE, 16'(m));
      servo_on(16'h0005);
      repeat (20) @(posedge clk);
      wr_reg(`SPS_IDX_CTRL, 16'h0004);
      for (int n = 0; n < 100 && !(stopped && !pwm); n++) @(posedge clk);
      repeat (3) @(posedge clk);
      chk("dynamic brake", {31'h0, ex[m]}, {31'h0, db});
    end
  endtask

  task automatic t_emergency_halt_input();
    servo_on(16'h0005);
    fwd <= 1'b1;
    repeat (6) @(posedge clk);
    chk("decel method 1", 32'h1, {31'h0, ed});
    chk("torque zero m1", 32'h0, {31'h0, tz});
    fwd <= 1'b0;
    wr_reg(`SPS_IDX_EMERGENCY_HALT_INPUT_METH, 16'h0000);
    rev <= 1'b1;
    repeat (6) @(posedge clk);
    chk("torque zero m0", 32'h1, {31'h0, tz});
    for (int n = 0; n < 50 && pwm; n++) @(posedge clk);
    chk("stopped m0", 32'h0, {31'h0, pwm});
    rev <= 1'b0;
    wr_reg(`SPS_IDX_EMERGENCY_HALT_INPUT_METH, 16'h0001);
    servo_on(16'h0007);
    halt <= 1'b1;
    repeat (6) @(posedge clk);
    chk("decel torque mode", 32'h0, {31'h0, ed});
    chk("zero torque mode", 32'h1, {31'h0, tz});
    halt <= 1'b0;
    wr_reg(`SPS_IDX_CTRL, 16'h0001);
    repeat (2) @(posedge clk);
    chk("regen internal", 32'h0, {31'h0, rgn});
    servo_on(16'h0005);
    repeat (2) @(posedge clk);
    chk("regen external", 32'h1, {31'h0, rgn});
  endtask

  task automatic t_overload();
    load <= 16'h00c8;
    repeat (50) @(posedge clk);
    rd_reg(`SPS_IDX_ACC);
    chk("figure below base", 32'h0, last_data);
    wr_reg(`SPS_IDX_ENABLE, 16'h0001);
    wr_reg(`SPS_IDX_OVL_BASE, 16'h000a);
    wr_reg(`SPS_IDX_WARN_LVL, 16'h000a);
    for (int n = 0; n < 400 && !warn[4]; n++) @(posedge clk);
    chk("overload warning", 32'h1, {31'h0, warn[4]});
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    load <= 16'h0000;
    for (int n = 0; n < 100 && warn[4]; n++) @(posedge clk);
    chk("warning drop", 32'h0, {31'h0, warn[4]});
    wr_reg(`SPS_IDX_CLEAR, 16'h001f);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    load <= 16'h00c8;
    for (int n = 0; n < 2600 && !ovl; n++) @(posedge clk);
    chk("overload alarm", 32'h1, {31'h0, ovl});
    // Masked warning outputs lag the internal warning by one register
    @(posedge clk);
    chk("warning replaced", 32'h0, {31'h0, warn[4]});
    rd_reg(`SPS_IDX_WARN_OUT);
    chk("warning word", 32'h8000, last_data);
    load <= 16'h0000;
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, awv, wv, brdy, arv, rrdy, fwd, rev, halt, idx} = '0;
    {awa, ara, wd, ws, wraw, load, cur_a, cur_b, cur_c} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_offsets();
    t_mask();
    t_off_delay(0);
    t_off_delay(2);
    t_modes();
    t_emergency_halt_input();
    t_overload();
    tally_and_finish();
  end

  // Whole run is near 3000 cycles; a hang is cut well beyond that
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
